// >>> core/fsp_section_ctrl.sv
// module: self-program section control, stall and busy flag
//
// Rules of the document for this block
// RULE_01 - store requests are taken only when fetched from the loader region
// RULE_02 - a loader-region store may target any page, loader pages included
// RULE_03 - readable-region page programming: cpu runs, halting region only read
// RULE_04 - halting-region page programming stalls the cpu the whole operation
// RULE_05 - software must not read the readable region while it programs
// RULE_06 - software should disable or relocate interrupts before programming
// RULE_07 - busy flag reads one while the readable region is blocked
// RULE_08 - software clears the busy flag after programming before reading it
// RULE_09 - the loader region always lies inside the halting region
// RULE_10 - boot-size fuses set the loader split; halting boundary is fixed
// RULE_11 - two independent lock sets: application set and loader set
// RULE_12 - lock bits set by software or programmer, cleared by chip erase
// RULE_13 - lock code 11 open, 10 no store, 00 no store/load, 01 no load
// RULE_14 - page address compared with fixed boundary parameter to pick mode
//
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module fsp_section_ctrl
#(
  parameter int                       ADDR_W       = fsp_pkg::ADDR_W,
  parameter logic [fsp_pkg::ADDR_W-1:0] HALT_BASE  = 16'hE000,
  parameter int                       PROG_CYCLES  = fsp_pkg::PROG_CYCLES
)
(
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  input  wire logic [1:0]              boot_size_fuses,
  input  wire logic                    prog_req,
  input  wire fsp_pkg::fsp_prog_req_t  prog_info,
  input  wire fsp_pkg::fsp_fetch_t     fetch,
  input  wire fsp_pkg::fsp_fetch_t     pm_load,
  input  wire logic                    ext_lock_wr,
  input  wire logic [3:0]              ext_lock_data,
  input  wire logic                    chip_erase,
  input  wire logic [3:0]              reg_addr,
  input  wire logic [7:0]              reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic [7:0]                   reg_rdata,
  output logic                         cpu_stall,
  output logic                         prog_start,
  output logic                         prog_refused,
  output logic                         fetch_allowed,
  output logic                         load_allowed,
  output logic                         prog_busy
);

  ////////////////////////////////////////////////////////////////////////////
  // region decode
  logic [ADDR_W-1:0] boot_base;
  logic              fetch_in_boot;
  logic              tgt_in_boot;
  logic              tgt_in_halt;
  logic              fetch_in_halt;
  logic              load_in_halt;
  logic              load_in_boot;

  // loader base never below the halting base, so loader stays inside it
  always_comb
  begin
    case (boot_size_fuses)                                  // RULE_10
      2'h0:    boot_base = HALT_BASE;                       // RULE_09
      2'h1:    boot_base = HALT_BASE + 16'h1000;
      2'h2:    boot_base = HALT_BASE + 16'h1800;
      default: boot_base = HALT_BASE + 16'h1C00;
    endcase
  end

  assign fetch_in_boot = fetch.valid && (fetch.addr >= boot_base); // RULE_01
  assign tgt_in_boot   = prog_info.addr >= boot_base;
  assign tgt_in_halt   = prog_info.addr >= HALT_BASE;       // RULE_14
  assign fetch_in_halt = fetch.addr >= HALT_BASE;
  assign load_in_halt  = pm_load.addr >= HALT_BASE;
  assign load_in_boot  = pm_load.addr >= boot_base;

  ////////////////////////////////////////////////////////////////////////////
  // lock sets
  logic [3:0] lock_r;
  logic [3:0] lock_nxt;
  logic       app_store_blk;
  logic       app_load_blk;
  logic       ldr_store_blk;
  logic       ldr_load_blk;

  fsp_lock_check u_app_lock
  (
    .lock_code     (lock_r[fsp_pkg::LOCK_APP_LO +: 2]),     // RULE_11
    .store_blocked (app_store_blk),
    .load_blocked  (app_load_blk)
  );

  fsp_lock_check u_ldr_lock
  (
    .lock_code     (lock_r[fsp_pkg::LOCK_LDR_LO +: 2]),     // RULE_11
    .store_blocked (ldr_store_blk),
    .load_blocked  (ldr_load_blk)
  );

  // programming only moves bits from 1 to 0; erase restores all ones
  always_comb
  begin
    lock_nxt = lock_r;
    if (reg_wr && reg_addr == fsp_pkg::OFS_LOCK)
      lock_nxt = lock_nxt & reg_wdata[3:0];                 // RULE_12
    if (ext_lock_wr)
      lock_nxt = lock_nxt & ext_lock_data;                  // RULE_12
    if (chip_erase)
      lock_nxt = fsp_pkg::LOCK_RESET;                       // RULE_12
  end

  ////////////////////////////////////////////////////////////////////////////
  // programming sequencer
  typedef enum logic [2:0]
  {
    ST_IDLE  = 3'b001,
    ST_RWW   = 3'b010,
    ST_HALT  = 3'b100
  } fsp_state_t;

  fsp_state_t  state_r;
  fsp_state_t  state_nxt;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic        busy_r;
  logic        busy_nxt;
  logic        stall_nxt;
  logic        start_nxt;
  logic        refuse_nxt;
  logic        fetch_ok_nxt;
  logic        load_ok_nxt;
  logic        store_lock_hit;
  logic        accept;
  logic        busy_clr;

  assign store_lock_hit = tgt_in_boot ? ldr_store_blk : app_store_blk;
  // only a fetch from the loader may start; any page is a legal target
  assign accept   = prog_req && fetch_in_boot && !store_lock_hit; // RULE_01 RULE_02
  assign busy_clr = reg_wr && reg_addr == fsp_pkg::OFS_CTRL_STATUS &&
                    reg_wdata[fsp_pkg::BIT_BUSY_CLR];

  always_comb
  begin
    state_nxt  = state_r;
    cnt_nxt    = cnt_r;
    busy_nxt   = busy_r;
    start_nxt  = 1'b0;
    refuse_nxt = 1'b0;
    case (state_r)
      ST_IDLE:
      begin
        if (prog_req && !accept)
          refuse_nxt = 1'b1;                                // RULE_01
        else if (accept)
        begin
          start_nxt = 1'b1;
          cnt_nxt   = 16'(PROG_CYCLES - 1);
          if (tgt_in_halt)
            state_nxt = ST_HALT;                            // RULE_04
          else
          begin
            state_nxt = ST_RWW;                             // RULE_03
            busy_nxt  = 1'b1;                               // RULE_07
          end
        end
        else if (busy_clr)
          busy_nxt = 1'b0;                                  // RULE_08
      end
      ST_RWW, ST_HALT:
      begin
        if (prog_req)
          refuse_nxt = 1'b1;
        if (cnt_r == 16'h0000)
          state_nxt = ST_IDLE;
        else
          cnt_nxt = cnt_r - 16'h0001;
      end
      default:
        state_nxt = ST_IDLE;
    endcase
    // region stays blocked until software clears the flag
    stall_nxt    = (state_nxt == ST_HALT);                  // RULE_04
    fetch_ok_nxt = (state_nxt == ST_IDLE && !busy_nxt) ||
                   (state_nxt != ST_HALT && fetch_in_halt); // RULE_03
    load_ok_nxt  = fetch_ok_nxt && pm_load.valid &&
                   ((state_nxt == ST_IDLE && !busy_nxt) || load_in_halt) &&
                   !(fetch_in_boot && !load_in_boot && app_load_blk) &&
                   !(!fetch_in_boot && load_in_boot && ldr_load_blk); // RULE_13
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers and read port
  logic [7:0] rdata_nxt;

  always_comb
  begin
    rdata_nxt = 8'h00;
    if (reg_rd)
      case (reg_addr)
        fsp_pkg::OFS_CTRL_STATUS:
          rdata_nxt[fsp_pkg::BIT_BUSY_FLAG] = busy_r;       // RULE_07
        fsp_pkg::OFS_LOCK:
          rdata_nxt = {4'h0, lock_r};
        fsp_pkg::OFS_BUSY_CNT:
          rdata_nxt = {5'h00, state_r};
        default:
          rdata_nxt = 8'h00;
      endcase
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r       <= ST_IDLE;
      cnt_r         <= 16'h0000;
      busy_r        <= 1'b0;
      lock_r        <= fsp_pkg::LOCK_RESET;
      reg_rdata     <= 8'h00;
      cpu_stall     <= 1'b0;
      prog_start    <= 1'b0;
      prog_refused  <= 1'b0;
      fetch_allowed <= 1'b1;
      load_allowed  <= 1'b0;
      prog_busy     <= 1'b0;
    end
    else
    begin
      state_r       <= state_nxt;
      cnt_r         <= cnt_nxt;
      busy_r        <= busy_nxt;
      lock_r        <= lock_nxt;
      reg_rdata     <= rdata_nxt;
      cpu_stall     <= stall_nxt;
      prog_start    <= start_nxt;
      prog_refused  <= refuse_nxt;
      fetch_allowed <= fetch_ok_nxt;
      load_allowed  <= load_ok_nxt;
      prog_busy     <= (state_nxt != ST_IDLE);
    end
  end

endmodule // fsp_section_ctrl
`default_nettype wire

// >>> core/fsp_pkg.sv
// package: constants and carriers for the self-program section control
package fsp_pkg;

  localparam int ADDR_W        = 16;
  localparam int PAGE_W        = 7;
  localparam int REG_ADDR_W    = 4;

  // register offsets (port-level register file)
  localparam logic [3:0] OFS_CTRL_STATUS = 4'h0;
  localparam logic [3:0] OFS_LOCK        = 4'h1;
  localparam logic [3:0] OFS_BUSY_CNT    = 4'h2;

  // ctrl/status field positions
  localparam int BIT_BUSY_CLR  = 4;
  localparam int BIT_BUSY_FLAG = 6;

  // lock field positions: application set bits 1:0, loader set bits 3:2
  localparam int LOCK_APP_LO   = 0;
  localparam int LOCK_LDR_LO   = 2;
  localparam logic [1:0] LOCK_OPEN     = 2'h3;
  localparam logic [1:0] LOCK_NO_STORE = 2'h2;
  localparam logic [1:0] LOCK_ALL      = 2'h0;
  localparam logic [1:0] LOCK_NO_LOAD  = 2'h1;
  localparam logic [3:0] LOCK_RESET    = 4'hF;

  // programming time
  localparam int PROG_TIME_NS  = 4000;
  localparam int CLK_PERIOD_NS = 5;
  localparam int PROG_CYCLES   = (PROG_TIME_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;

  typedef struct packed {
    logic              erase;
    logic [ADDR_W-1:0] addr;
  } fsp_prog_req_t;

  typedef struct packed {
    logic              valid;
    logic [ADDR_W-1:0] addr;
  } fsp_fetch_t;

endpackage : fsp_pkg

// >>> core/fsp_lock_check.sv
// module: one lock set decoder for one flash region
`timescale 1ns/10ps
`default_nettype none
module fsp_lock_check
(
  input  wire logic [1:0] lock_code,
  output logic            store_blocked,
  output logic            load_blocked
);
  always_comb
  begin
    store_blocked = (lock_code == fsp_pkg::LOCK_NO_STORE) ||
                    (lock_code == fsp_pkg::LOCK_ALL);       // RULE_13
    load_blocked  = (lock_code == fsp_pkg::LOCK_NO_LOAD) ||
                    (lock_code == fsp_pkg::LOCK_ALL);       // RULE_13
  end
endmodule // fsp_lock_check
`default_nettype wire

// >>> dv/fsp_section_ctrl_monitor.sv
// checker: timing relations at the section control ports
`timescale 1ns/10ps
`default_nettype none
module fsp_section_ctrl_monitor
#(
  parameter logic [15:0] HALT_BASE = 16'hE000
)
(
  input wire logic                   clock,
  input wire logic                   rst_n,
  input wire logic                   prog_req,
  input wire fsp_pkg::fsp_prog_req_t prog_info,
  input wire fsp_pkg::fsp_fetch_t    fetch,
  input wire logic [3:0]             reg_addr,
  input wire logic                   reg_rd,
  input wire logic [7:0]             reg_rdata,
  input wire logic                   cpu_stall,
  input wire logic                   prog_start,
  input wire logic                   prog_refused,
  input wire logic                   fetch_allowed,
  input wire logic                   prog_busy
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // repeat counts assume the bench runs PROG_CYCLES = 4
  sequence s_busy_op;
    prog_busy[*4] ##1 !prog_busy;
  endsequence
  sequence s_halt_op;
    cpu_stall[*4] ##1 !cpu_stall;
  endsequence
  property p_app_refused;
    prog_req && fetch.addr < HALT_BASE |=> prog_refused && !prog_start;
  endproperty
  a_app_refused: assert property (p_app_refused)
    else $error("store from application region not refused");
  property p_one_answer;
    prog_req |=> prog_start != prog_refused;
  endproperty
  a_one_answer: assert property (p_one_answer)
    else $error("store request without single answer");
  property p_start_ldr;
    prog_start |-> $past(fetch.addr) >= HALT_BASE;
  endproperty
  a_start_ldr: assert property (p_start_ldr)
    else $error("store accepted from outside halting region");
  property p_run_len;
    prog_start |-> s_busy_op;
  endproperty
  a_run_len: assert property (p_run_len)
    else $error("programming length wrong");
  property p_halt_stall;
    prog_start && $past(prog_info.addr) >= HALT_BASE |-> s_halt_op;
  endproperty
  a_halt_stall: assert property (p_halt_stall)
    else $error("halting region target did not stall cpu");
  property p_rww_run;
    prog_start && $past(prog_info.addr) < HALT_BASE |-> (!cpu_stall)[*4];
  endproperty
  a_rww_run: assert property (p_rww_run)
    else $error("cpu stalled during readable region programming");
  property p_rww_fetch;
    $past(prog_busy && !cpu_stall && fetch.valid) && prog_busy
      |-> fetch_allowed == ($past(fetch.addr) >= HALT_BASE);
  endproperty
  a_rww_fetch: assert property (p_rww_fetch)
    else $error("fetch permission wrong while programming");
  property p_flag_read;
    reg_rd && reg_addr == fsp_pkg::OFS_CTRL_STATUS && prog_busy && !cpu_stall
      |=> reg_rdata[fsp_pkg::BIT_BUSY_FLAG];
  endproperty
  a_flag_read: assert property (p_flag_read)
    else $error("busy flag reads zero while region blocked");
endmodule // fsp_section_ctrl_monitor
////////////////////////////////////////////////////////////////////////////////
bind fsp_section_ctrl fsp_section_ctrl_monitor #(.HALT_BASE(HALT_BASE)) i_mon (
  .clock(clock), .rst_n(rst_n), .prog_req(prog_req), .prog_info(prog_info),
  .fetch(fetch), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .cpu_stall(cpu_stall), .prog_start(prog_start),
  .prog_refused(prog_refused), .fetch_allowed(fetch_allowed),
  .prog_busy(prog_busy));
`default_nettype wire

// >>> dv/fsp_cpu_model.sv
// partner: cpu issuing store and load program memory operations
`timescale 1ns/10ps
`default_nettype none
module fsp_cpu_model
(
  input  wire logic                  clock,
  output logic                       prog_req,
  output var fsp_pkg::fsp_prog_req_t prog_info,
  output var fsp_pkg::fsp_fetch_t    fetch,
  output var fsp_pkg::fsp_fetch_t    pm_load
);
  initial
  begin
    prog_req = 1'b0;
    prog_info = '0;
    fetch = {1'b1, 16'h0000};
    pm_load = '0;
  end
  // callers keep fetch off the blocked region while it programs
  task automatic store(input logic [15:0] fa, input logic [15:0] ta);
    @(posedge clock);
    fetch <= {1'b1, fa};
    prog_info <= {1'b0, ta};
    prog_req <= 1'b1;
    @(posedge clock);
    prog_req <= 1'b0;
    // target no longer qualified: scramble so a stale value cannot help
    prog_info <= ~prog_info;
  endtask
  task automatic load(input logic [15:0] a);
    @(posedge clock);
    pm_load <= {1'b1, a};
  endtask
endmodule // fsp_cpu_model
`default_nettype wire

// >>> dv/fsp_section_ctrl_tb_top.sv
// testbench: section control driven by a cpu model and register tasks
`timescale 1ns/10ps
`default_nettype none
module fsp_section_ctrl_tb_top;
  logic                   clock;
  logic                   rst_n;
  logic [1:0]             boot_size_fuses;
  logic                   prog_req;
  fsp_pkg::fsp_prog_req_t prog_info;
  fsp_pkg::fsp_fetch_t    fetch;
  fsp_pkg::fsp_fetch_t    pm_load;
  logic                   ext_lock_wr;
  logic [3:0]             ext_lock_data;
  logic                   chip_erase;
  logic [3:0]             reg_addr;
  logic [7:0]             reg_wdata;
  logic                   reg_wr;
  logic                   reg_rd;
  logic [7:0]             reg_rdata;
  logic                   cpu_stall;
  logic                   prog_start;
  logic                   prog_refused;
  logic                   fetch_allowed;
  logic                   load_allowed;
  logic                   prog_busy;
  logic [7:0]             d;
  int                     num_errors;
  int                     n_checks;
  // short programming time keeps the run brief
  fsp_section_ctrl #(.PROG_CYCLES(4)) i_fsp_section_ctrl (.clock, .rst_n,
    .boot_size_fuses, .prog_req, .prog_info, .fetch, .pm_load, .ext_lock_wr,
    .ext_lock_data, .chip_erase, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .cpu_stall, .prog_start, .prog_refused, .fetch_allowed,
    .load_allowed, .prog_busy);
  fsp_cpu_model i_cpu (.clock, .prog_req, .prog_info, .fetch, .pm_load);
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic st(input logic [15:0] fa, input logic [15:0] ta,
                    input logic ok);
    i_cpu.store(fa, ta);
    // start and refused stand for one cycle only: look inside it
    #1 chk(8'(prog_start), 8'(ok));
    chk(8'(prog_refused), 8'(!ok));
  endtask
  task automatic print_verdict;
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial
  begin
    #5000;
    num_errors++;
    print_verdict;
  end
  initial
  begin
    {rst_n, ext_lock_wr, chip_erase, reg_wr, reg_rd} = '0;
    boot_size_fuses = 2'h3;
    ext_lock_data = 4'hF;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    num_errors = 0;
    n_checks = 0;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    rd(fsp_pkg::OFS_LOCK, d);
    chk(d, 8'h0F);
    st(16'hE100, 16'h0100, 1'b0);
    st(16'h0200, 16'h0100, 1'b0);
    @(posedge clock) boot_size_fuses <= 2'h0;
    st(16'hE100, 16'h0100, 1'b1);
    chk(8'(prog_busy), 8'h01);
    chk(8'(cpu_stall), 8'h00);
    chk(8'(fetch_allowed), 8'h01);
    rd(fsp_pkg::OFS_CTRL_STATUS, d);
    chk(8'(d[fsp_pkg::BIT_BUSY_FLAG]), 8'h01);
    repeat (6) @(posedge clock);
    rd(fsp_pkg::OFS_CTRL_STATUS, d);
    chk(8'(d[fsp_pkg::BIT_BUSY_FLAG]), 8'h01);
    wr(fsp_pkg::OFS_CTRL_STATUS, 8'h10);
    rd(fsp_pkg::OFS_CTRL_STATUS, d);
    chk(8'(d[fsp_pkg::BIT_BUSY_FLAG]), 8'h00);
    st(16'hF000, 16'hF100, 1'b1);
    chk(8'(cpu_stall), 8'h01);
    repeat (6) @(posedge clock);
    i_cpu.load(16'h0100);
    repeat (2) @(posedge clock);
    #1 chk(8'(load_allowed), 8'h01);
    wr(fsp_pkg::OFS_LOCK, 8'h0D);
    repeat (2) @(posedge clock);
    #1 chk(8'(load_allowed), 8'h00);
    wr(fsp_pkg::OFS_LOCK, 8'h0E);
    st(16'hE000, 16'h0100, 1'b0);
    st(16'hE000, 16'hF100, 1'b1);
    repeat (6) @(posedge clock);
    ext_lock_data <= 4'h3;
    ext_lock_wr <= 1'b1;
    @(posedge clock) ext_lock_wr <= 1'b0;
    st(16'hE000, 16'hF100, 1'b0);
    @(posedge clock) chip_erase <= 1'b1;
    @(posedge clock) chip_erase <= 1'b0;
    rd(fsp_pkg::OFS_LOCK, d);
    chk(d, 8'h0F);
    print_verdict;
  end
endmodule // fsp_section_ctrl_tb_top
`default_nettype wire
